// ---- shared/smc_pkg.sv ----
// standby mode controller: shared constants, mode encodings and types
// assumes one 200 MHz clock; the 32 kHz clock arrives as a sampled level
//
// Contract
// - standby needs both sleep request pins active together.
// - each pin has its own polarity bit; 0 active high, 1 active low.
// - sleep pins only matter in the On state, ignored otherwise.
// - a lowpower off command overrides any standby request.
// - entry waits 0..3 periods of 32 kHz per the two-bit delay field.
// - leaving standby is immediate, with no delay.
// - external-pass regulator mode from enable, lowpower select and response.
// - internal regulators, outputs: off if disabled or responding in standby.
// - with its response bit clear, standby leaves that output untouched.
// - readback shows the programmed values, not the modified state.
// - codes 0000..0100 give normal modes, off in standby; 0111 illegal.
// - switcher codes 0101..1111 map normal/standby mode pairs.
// - auto mode moves between pulse-skipping pwm and pfm on load alone.
// - switchers may keep running in pfm through user-off and memory-hold.
package smc_pkg;

  // ----------------------------------------
  // widths, defaults and counts
  // ----------------------------------------
  localparam int SMC_DLY_W = 2;
  localparam int SMC_SWM_W = 4;
  localparam logic [SMC_DLY_W-1:0] SMC_DLY_DEFAULT = 2'h1;
  localparam logic [SMC_DLY_W-1:0] SMC_DLY_NONE = 2'h0;
  localparam logic [SMC_DLY_W-1:0] SMC_CNT_RST = 2'h0;

  // ----------------------------------------
  // switcher mode field codes (normal / standby)
  // ----------------------------------------
  localparam logic [SMC_SWM_W-1:0] SMC_SWM_OFF_OFF = 4'h0;
  localparam logic [SMC_SWM_W-1:0] SMC_SWM_PWM_OFF = 4'h1;
  localparam logic [SMC_SWM_W-1:0] SMC_SWM_SKIP_OFF = 4'h2;
  localparam logic [SMC_SWM_W-1:0] SMC_SWM_PFM_OFF = 4'h3;
  localparam logic [SMC_SWM_W-1:0] SMC_SWM_AUTO_OFF = 4'h4;
  localparam logic [SMC_SWM_W-1:0] SMC_SWM_PWM_PWM = 4'h5;
  localparam logic [SMC_SWM_W-1:0] SMC_SWM_PWM_AUTO = 4'h6;
  localparam logic [SMC_SWM_W-1:0] SMC_SWM_ILLEGAL = 4'h7;
  localparam logic [SMC_SWM_W-1:0] SMC_SWM_AUTO_AUTO = 4'h8;
  localparam logic [SMC_SWM_W-1:0] SMC_SWM_PWM_SKIP = 4'h9;
  localparam logic [SMC_SWM_W-1:0] SMC_SWM_SKIP_SKIP = 4'ha;
  localparam logic [SMC_SWM_W-1:0] SMC_SWM_SKIP_AUTO = 4'hb;
  localparam logic [SMC_SWM_W-1:0] SMC_SWM_AUTO_PFM = 4'hc;
  localparam logic [SMC_SWM_W-1:0] SMC_SWM_PWM_PFM = 4'hd;
  localparam logic [SMC_SWM_W-1:0] SMC_SWM_SKIP_PFM = 4'he;
  localparam logic [SMC_SWM_W-1:0] SMC_SWM_PFM_PFM = 4'hf;

  // ----------------------------------------
  // types
  // ----------------------------------------
  // requested mode, before auto is resolved against load
  typedef enum logic [2:0] {
    SMC_REQ_OFF,
    SMC_REQ_PWM,
    SMC_REQ_PULSE_SKIPPING_PWM,
    SMC_REQ_PFM,
    SMC_REQ_AUTO
  } smc_req_type;

  // mode the switcher actually runs in
  typedef enum logic [1:0] {
    SMC_OP_OFF,
    SMC_OP_PWM,
    SMC_OP_PULSE_SKIPPING_PWM,
    SMC_OP_PFM
  } smc_op_type;

  typedef struct packed {
    smc_req_type normal;
    smc_req_type standby;
  } smc_pair_type;

  // first state must be the reset state
  typedef enum logic [1:0] {
    SMC_AWAKE,
    SMC_ENTRY_WAIT,
    SMC_ASLEEP
  } smc_seq_type;

endpackage

// ---- shared/smc_sw_if.sv ----
// switcher decode carrier between the sequencer and one mode decoder
// assumes the sequencer drives all inputs combinationally
`timescale 1ns/100ps
interface smc_sw_if;
  import smc_pkg::*;
  logic [SMC_SWM_W-1:0] mode_field;
  logic sleep;
  logic lpo;
  logic keep;
  logic light;
  smc_op_type op;
  logic illegal;
  modport dec (
    input mode_field,
    input sleep,
    input lpo,
    input keep,
    input light,
    output op,
    output illegal
  );
  modport ctl (
    output mode_field,
    output sleep,
    output lpo,
    output keep,
    output light,
    input op,
    input illegal
  );
endinterface

// ---- hw/smc_sw_decode.sv ----
// one buck switcher mode decoder, purely combinational
// assumes the sequencer registers the resulting mode
`timescale 1ns/100ps
module smc_sw_decode
  import smc_pkg::*;
(
  smc_sw_if.dec sw
);

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  function automatic smc_pair_type decode_field(
    input logic [SMC_SWM_W-1:0] f
  );
    smc_pair_type p;
    p = '{SMC_REQ_OFF, SMC_REQ_OFF};
    case (f)
      SMC_SWM_OFF_OFF: p = '{SMC_REQ_OFF, SMC_REQ_OFF};
      SMC_SWM_PWM_OFF: p = '{SMC_REQ_PWM, SMC_REQ_OFF};
      SMC_SWM_SKIP_OFF:
        p = '{SMC_REQ_PULSE_SKIPPING_PWM, SMC_REQ_OFF};
      SMC_SWM_PFM_OFF: p = '{SMC_REQ_PFM, SMC_REQ_OFF};
      SMC_SWM_AUTO_OFF: p = '{SMC_REQ_AUTO, SMC_REQ_OFF};
      SMC_SWM_PWM_PWM: p = '{SMC_REQ_PWM, SMC_REQ_PWM};
      SMC_SWM_PWM_AUTO: p = '{SMC_REQ_PWM, SMC_REQ_AUTO};
      SMC_SWM_AUTO_AUTO: p = '{SMC_REQ_AUTO, SMC_REQ_AUTO};
      SMC_SWM_PWM_SKIP:
        p = '{SMC_REQ_PWM, SMC_REQ_PULSE_SKIPPING_PWM};
      SMC_SWM_SKIP_SKIP:
        p = '{SMC_REQ_PULSE_SKIPPING_PWM,
              SMC_REQ_PULSE_SKIPPING_PWM};
      SMC_SWM_SKIP_AUTO:
        p = '{SMC_REQ_PULSE_SKIPPING_PWM, SMC_REQ_AUTO};
      SMC_SWM_AUTO_PFM: p = '{SMC_REQ_AUTO, SMC_REQ_PFM};
      SMC_SWM_PWM_PFM: p = '{SMC_REQ_PWM, SMC_REQ_PFM};
      SMC_SWM_SKIP_PFM:
        p = '{SMC_REQ_PULSE_SKIPPING_PWM, SMC_REQ_PFM};
      SMC_SWM_PFM_PFM: p = '{SMC_REQ_PFM, SMC_REQ_PFM};
      // illegal code: safest answer is to keep the switcher off
      default: p = '{SMC_REQ_OFF, SMC_REQ_OFF};
    endcase
    return p;
  endfunction

  smc_pair_type pair;
  smc_req_type req;

  always_comb
  begin
    pair = decode_field(sw.mode_field);
    req = sw.sleep ? pair.standby : pair.normal;
    sw.illegal = (sw.mode_field == SMC_SWM_ILLEGAL);
    if (sw.lpo)
    begin
      // lowpower off: only pfm retention or off
      sw.op = sw.keep ? SMC_OP_PFM : SMC_OP_OFF;
    end
    else
    begin
      case (req)
        SMC_REQ_PWM: sw.op = SMC_OP_PWM;
        SMC_REQ_PULSE_SKIPPING_PWM: sw.op = SMC_OP_PULSE_SKIPPING_PWM;
        SMC_REQ_PFM: sw.op = SMC_OP_PFM;
        // auto follows the load with no software action
        SMC_REQ_AUTO:
          sw.op = sw.light ? SMC_OP_PFM
                           : SMC_OP_PULSE_SKIPPING_PWM;
        default: sw.op = SMC_OP_OFF;
      endcase
    end
  end

endmodule

// ---- hw/smc_top.sv ----
// standby mode controller: sleep request decode, entry delay and
// per-supply mode selection for regulators, outputs and switchers
// assumes all inputs are synchronous to clk_sys_i; the 32 kHz clock
// is sampled as a level and only its rising edges are used
// limitation: the first delay period may be partial, since counting
// starts at the first slow edge after the request
`timescale 1ns/100ps
module smc_top
  import smc_pkg::*;
#(
  parameter int N_EXT = 4,
  parameter int N_INT = 6,
  parameter int N_GPO = 4,
  parameter int N_SW = 4
)
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,

  // sleep request pins and their set-up
  input wire logic primary_sleep_request_i,
  input wire logic secondary_sleep_request_i,
  input wire logic primary_sleep_polarity_i,
  input wire logic secondary_sleep_polarity_i,
  input wire logic [smc_pkg::SMC_DLY_W-1:0] sleep_entry_delay_i,
  input wire logic slow_clk_32k_i,

  // device operating state and software commands
  input wire logic on_state_i,
  input wire logic user_off_state_i,
  input wire logic memory_hold_state_i,
  input wire logic lowpower_off_command_i,

  // external-pass regulators
  input wire logic [N_EXT-1:0] ext_regulator_enable_bit_i,
  input wire logic [N_EXT-1:0] ext_regulator_lowpower_select_i,
  input wire logic [N_EXT-1:0] ext_regulator_sleep_response_i,

  // internal-pass regulators
  input wire logic [N_INT-1:0] int_regulator_enable_bit_i,
  input wire logic [N_INT-1:0] int_regulator_sleep_response_i,

  // general purpose outputs
  input wire logic [N_GPO-1:0] general_purpose_output_enable_i,
  input wire logic [N_GPO-1:0] general_purpose_output_sleep_response_i,

  // buck switchers
  input wire logic [N_SW-1:0][smc_pkg::SMC_SWM_W-1:0]
    switcher_mode_field_i,
  input wire logic [N_SW-1:0] switcher_user_off_keep_i,
  input wire logic [N_SW-1:0] switcher_memory_hold_keep_i,
  input wire logic [N_SW-1:0] switcher_light_load_i,

  // standby status
  output logic sleep_active_o,
  output logic sleep_entry_pending_o,

  // supply controls
  output logic [N_EXT-1:0] ext_regulator_on_o,
  output logic [N_EXT-1:0] ext_regulator_lowpower_o,
  output logic [N_INT-1:0] int_regulator_on_o,
  output logic [N_GPO-1:0] general_purpose_output_o,
  output smc_pkg::smc_op_type [N_SW-1:0] switcher_op_o,
  output logic [N_SW-1:0] switcher_mode_illegal_o,

  // configuration readback
  output logic [N_EXT-1:0] rb_ext_regulator_enable_bit_o,
  output logic [N_EXT-1:0] rb_ext_regulator_lowpower_select_o,
  output logic [N_INT-1:0] rb_int_regulator_enable_bit_o,
  output logic [N_SW-1:0][smc_pkg::SMC_SWM_W-1:0]
    rb_switcher_mode_field_o
);
  import smc_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    // sequencer and slow edge detect
    smc_seq_type seq;
    logic [SMC_DLY_W-1:0] cnt;
    logic tick_prev;

    // supply controls
    logic [N_EXT-1:0] ext_on;
    logic [N_EXT-1:0] ext_lp;
    logic [N_INT-1:0] int_on;
    logic [N_GPO-1:0] general_purpose_output;
    smc_op_type [N_SW-1:0] sw_op;
    logic [N_SW-1:0] sw_illegal;

    // copies of the programmed set-up
    logic [N_EXT-1:0] rb_ext_en;
    logic [N_EXT-1:0] rb_ext_lp;
    logic [N_INT-1:0] rb_int_en;
    logic [N_SW-1:0][SMC_SWM_W-1:0] rb_swm;
  } smc_state_type;

  smc_state_type q;
  smc_state_type d;

  // ----------------------------------------
  // switcher decoders
  // ----------------------------------------
  smc_sw_if sw_if[N_SW]();
  smc_op_type [N_SW-1:0] sw_op_w;
  logic [N_SW-1:0] sw_illegal_w;
  logic sleep_nx;
  logic lpo_w;

  // either low-power off state overrides the mode field
  assign lpo_w = user_off_state_i | memory_hold_state_i;

  for (genvar i = 0; i < N_SW; i++)
  begin : g_sw
    assign sw_if[i].mode_field = switcher_mode_field_i[i];
    // next sleep state, so switcher modes move with the status
    assign sw_if[i].sleep = sleep_nx;
    assign sw_if[i].lpo = lpo_w;
    // retention chosen per low-power off state
    assign sw_if[i].keep =
      (user_off_state_i & switcher_user_off_keep_i[i]) |
      (memory_hold_state_i & switcher_memory_hold_keep_i[i]);
    assign sw_if[i].light = switcher_light_load_i[i];
    assign sw_op_w[i] = sw_if[i].op;
    assign sw_illegal_w[i] = sw_if[i].illegal;
    smc_sw_decode u_dec (
      .sw(sw_if[i].dec)
    );
  end

  // ----------------------------------------
  // request decode
  // ----------------------------------------
  // polarity bit 1 means the pin is active low
  function automatic logic pin_active(input logic pin, input logic inv);
    return pin ^ inv;
  endfunction

  logic req_w;
  logic tick_edge_w;

  always_comb
  begin
    // the on state and the off command gate the pins
    req_w = pin_active(primary_sleep_request_i,
                       primary_sleep_polarity_i) &
            pin_active(secondary_sleep_request_i,
                       secondary_sleep_polarity_i) &
            on_state_i &
            ~lowpower_off_command_i;
    // no added latency: the live slow level is compared with last cycle's sample
    tick_edge_w = slow_clk_32k_i & ~q.tick_prev;
  end

  // ----------------------------------------
  // sequencer and output selection
  // ----------------------------------------
  always_comb
  begin
    d = q;
    d.tick_prev = slow_clk_32k_i;

    case (q.seq)
      SMC_AWAKE:
      begin
        d.cnt = SMC_CNT_RST;
        if (req_w)
        begin
          if (sleep_entry_delay_i == SMC_DLY_NONE)
          begin
            d.seq = SMC_ASLEEP;
          end
          else
          begin
            d.seq = SMC_ENTRY_WAIT;
          end
        end
      end

      SMC_ENTRY_WAIT:
      begin
        if (!req_w)
        begin
          // a dropped request abandons the entry
          d.seq = SMC_AWAKE;
          d.cnt = SMC_CNT_RST;
        end
        else if (tick_edge_w)
        begin
          // only slow rising edges advance the count
          d.cnt = q.cnt + 2'h1;
          if (d.cnt >= sleep_entry_delay_i)
          begin
            d.seq = SMC_ASLEEP;
            d.cnt = SMC_CNT_RST;
          end
        end
      end

      SMC_ASLEEP:
      begin
        if (!req_w)
        begin
          // exit waits for no slow edge
          d.seq = SMC_AWAKE;
        end
      end

      default:
      begin
        d.seq = SMC_AWAKE;
        d.cnt = SMC_CNT_RST;
      end
    endcase

    // outputs follow the next state so exit costs no extra cycle
    sleep_nx = (d.seq == SMC_ASLEEP);

    for (int i = 0; i < N_EXT; i++)
    begin
      if (!ext_regulator_enable_bit_i[i])
      begin
        d.ext_on[i] = 1'b0;
        d.ext_lp[i] = 1'b0;
      end
      else if (!ext_regulator_sleep_response_i[i] || !sleep_nx)
      begin
        // response clear: standby has no say
        d.ext_on[i] = 1'b1;
        d.ext_lp[i] = ext_regulator_lowpower_select_i[i];
      end
      else
      begin
        // standby with response set: mode 0 off, mode 1 low-power
        d.ext_on[i] = ext_regulator_lowpower_select_i[i];
        d.ext_lp[i] = ext_regulator_lowpower_select_i[i];
      end
    end

    // internal-pass supplies have no low-power mode
    for (int i = 0; i < N_INT; i++)
    begin
      d.int_on[i] = int_regulator_enable_bit_i[i] &
        ~(int_regulator_sleep_response_i[i] & sleep_nx);
    end

    for (int i = 0; i < N_GPO; i++)
    begin
      d.general_purpose_output[i] = general_purpose_output_enable_i[i] &
        ~(general_purpose_output_sleep_response_i[i] &
          sleep_nx);
    end

    // switcher modes arrive from the decoders already resolved
    d.sw_op = sw_op_w;
    d.sw_illegal = sw_illegal_w;

    // readback is the programmed set-up, never the modified state
    d.rb_ext_en = ext_regulator_enable_bit_i;
    d.rb_ext_lp = ext_regulator_lowpower_select_i;
    d.rb_int_en = int_regulator_enable_bit_i;
    d.rb_swm = switcher_mode_field_i;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      // all zero is awake, count clear and every supply off
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // status
  assign sleep_active_o = (q.seq == SMC_ASLEEP);
  assign sleep_entry_pending_o = (q.seq == SMC_ENTRY_WAIT);

  // supply controls
  assign ext_regulator_on_o = q.ext_on;
  assign ext_regulator_lowpower_o = q.ext_lp;
  assign int_regulator_on_o = q.int_on;
  assign general_purpose_output_o = q.general_purpose_output;
  assign switcher_op_o = q.sw_op;
  assign switcher_mode_illegal_o = q.sw_illegal;

  // readback
  assign rb_ext_regulator_enable_bit_o = q.rb_ext_en;
  assign rb_ext_regulator_lowpower_select_o = q.rb_ext_lp;
  assign rb_int_regulator_enable_bit_o = q.rb_int_en;
  assign rb_switcher_mode_field_o = q.rb_swm;

endmodule

// ---- testbench/smc_properties.sv ----
// assertions on the standby controller top ports
// assumes one clock domain and a synchronous active low reset
`timescale 1ns/100ps
module smc_checker
  import smc_pkg::*;
#(
  parameter int N_EXT = 4,
  parameter int N_INT = 6,
  parameter int N_GPO = 4,
  parameter int N_SW = 4
)
(
  // clock, reset and requests
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic primary_sleep_request_i,
  input wire logic secondary_sleep_request_i,
  input wire logic primary_sleep_polarity_i,
  input wire logic secondary_sleep_polarity_i,
  input wire logic [smc_pkg::SMC_DLY_W-1:0] sleep_entry_delay_i,
  input wire logic slow_clk_32k_i,
  input wire logic on_state_i,
  input wire logic lowpower_off_command_i,
  // supply set-up
  input wire logic [N_EXT-1:0] ext_regulator_enable_bit_i,
  input wire logic [N_EXT-1:0] ext_regulator_lowpower_select_i,
  input wire logic [N_EXT-1:0] ext_regulator_sleep_response_i,
  input wire logic [N_INT-1:0] int_regulator_enable_bit_i,
  input wire logic [N_INT-1:0] int_regulator_sleep_response_i,
  input wire logic [N_GPO-1:0] general_purpose_output_enable_i,
  input wire logic [N_GPO-1:0] general_purpose_output_sleep_response_i,
  input wire logic [N_SW-1:0][smc_pkg::SMC_SWM_W-1:0]
    switcher_mode_field_i,
  // outputs watched
  input wire logic sleep_active_o,
  input wire logic sleep_entry_pending_o,
  input wire logic [N_EXT-1:0] ext_regulator_on_o,
  input wire logic [N_EXT-1:0] ext_regulator_lowpower_o,
  input wire logic [N_INT-1:0] int_regulator_on_o,
  input wire logic [N_GPO-1:0] general_purpose_output_o,
  input wire logic [N_SW-1:0] switcher_mode_illegal_o,
  input wire logic [N_EXT-1:0] rb_ext_regulator_enable_bit_o
);
  import smc_pkg::*;
  // ----------------------------------------
  // decoded request
  // ----------------------------------------
  logic req;
  logic [N_SW-1:0] ill;
  always_comb
  begin
    req = (primary_sleep_request_i ^ primary_sleep_polarity_i) &
      (secondary_sleep_request_i ^ secondary_sleep_polarity_i) &
      on_state_i & ~lowpower_off_command_i;
    for (int i = 0; i < N_SW; i++)
      ill[i] = switcher_mode_field_i[i] == 4'h7;
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  a_sleep_needs_req: assert property (
    !req |=> !sleep_active_o) else $error("sleep without request");
  a_off_state_ignored: assert property (
    !on_state_i |=> !sleep_active_o) else $error("sleep outside on");
  a_lowpower_off_wins: assert property (
    lowpower_off_command_i |=> !sleep_active_o) else $error("off lost");
  a_zero_delay_entry: assert property (
    req && sleep_entry_delay_i == 2'h0 && !sleep_entry_pending_o
    |=> sleep_active_o) else $error("no prompt entry");
  a_delay_starts_wait: assert property (
    req && sleep_entry_delay_i != 2'h0 && !sleep_active_o
    |=> sleep_entry_pending_o || sleep_active_o) else $error("no wait");
  a_entry_on_slow: assert property (
    $rose(sleep_active_o) && sleep_entry_delay_i != 2'h0
    |-> $past(slow_clk_32k_i, 1) && !$past(slow_clk_32k_i, 2))
    else $error("entry off slow edge");
  a_cancel_clears_wait: assert property (
    sleep_entry_pending_o && !req
    |=> !sleep_entry_pending_o && !sleep_active_o) else $error("no cancel");
  a_ext_reg_map: assert property (
    1 |=> ext_regulator_on_o == ($past(ext_regulator_enable_bit_i) &
    ~($past(ext_regulator_sleep_response_i) &
    ~$past(ext_regulator_lowpower_select_i) & {N_EXT{sleep_active_o}}))
    && (ext_regulator_lowpower_o & ext_regulator_on_o) ==
    ($past(ext_regulator_lowpower_select_i) & ext_regulator_on_o))
    else $error("ext regulator mode");
  a_int_reg_map: assert property (
    1 |=> int_regulator_on_o == ($past(int_regulator_enable_bit_i) &
    ~($past(int_regulator_sleep_response_i) & {N_INT{sleep_active_o}})))
    else $error("int regulator mode");
  a_gpo_map: assert property (
    1 |=> general_purpose_output_o ==
    ($past(general_purpose_output_enable_i) &
    ~($past(general_purpose_output_sleep_response_i) &
    {N_GPO{sleep_active_o}}))) else $error("output level");
  a_readback_programmed: assert property (
    1 |=> rb_ext_regulator_enable_bit_o ==
    $past(ext_regulator_enable_bit_i)) else $error("readback");
  a_illegal_code_flag: assert property (
    1 |=> switcher_mode_illegal_o == $past(ill)) else $error("illegal");
  c_long_entry: cover property ($rose(sleep_active_o) &&
    sleep_entry_delay_i == 2'h3);
  c_cancelled: cover property ($fell(sleep_entry_pending_o) &&
    !sleep_active_o);
  c_illegal: cover property (|switcher_mode_illegal_o);
endmodule

bind smc_top smc_checker #(.N_EXT(N_EXT), .N_INT(N_INT), .N_GPO(N_GPO),
  .N_SW(N_SW)) u_chk (.*);

// ---- testbench/smc_ap_model.sv ----
// processor side: drives the two sleep pins and the 32 kHz clock
// assumes the bench asks for active or idle pins and sets polarity
`timescale 1ns/100ps
module smc_ap_model
(
  // requests from the bench
  input wire logic want_primary_i,
  input wire logic want_secondary_i,
  input wire logic primary_polarity_i,
  input wire logic secondary_polarity_i,
  // pins
  output logic primary_pin_o,
  output logic secondary_pin_o,
  output logic slow_clk_o
);
  // 32 kHz runs free, its edges landing on system clock falling edges
  initial slow_clk_o = 1'b0;
  always #15625 slow_clk_o = ~slow_clk_o;
  // a set polarity bit means the pin idles high
  assign primary_pin_o = want_primary_i ^ primary_polarity_i;
  assign secondary_pin_o = want_secondary_i ^ secondary_polarity_i;
endmodule

// ---- testbench/smc_top_tb.sv ----
// self-checking bench for the standby mode controller
// assumes the checker is bound in; inputs change at falling edges
`timescale 1ns/100ps
module smc_top_tb;
  import smc_pkg::*;
  logic clk_sys_i, rst_n_i, want_p, want_s, pol_p, pol_s, pin_p, pin_s;
  logic slow, on_st, uo_st, mh_st, lpo, sleep, pend;
  logic [1:0] dly;
  logic [3:0] ext_en, ext_lp, ext_rs, gpo_en, gpo_rs, uo_keep, mh_keep;
  logic [3:0] light, ext_on, ext_lpo, gpo_o, sw_ill, rb_ext_en, rb_ext_lp;
  logic [5:0] int_en, int_rs, int_on, rb_int_en;
  logic [3:0][3:0] swf, rb_swf;
  smc_op_type [3:0] sw_op;
  int err_total = 0;
  int check_count = 0;
  int slow_edges = 0;
  always #2.5 clk_sys_i = ~clk_sys_i;
  always @(posedge slow) slow_edges++;
  smc_ap_model u_ap (.want_primary_i(want_p), .want_secondary_i(want_s),
    .primary_polarity_i(pol_p), .secondary_polarity_i(pol_s),
    .primary_pin_o(pin_p), .secondary_pin_o(pin_s), .slow_clk_o(slow));
  smc_top DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .primary_sleep_request_i(pin_p), .secondary_sleep_request_i(pin_s),
    .primary_sleep_polarity_i(pol_p), .secondary_sleep_polarity_i(pol_s),
    .sleep_entry_delay_i(dly), .slow_clk_32k_i(slow), .on_state_i(on_st),
    .user_off_state_i(uo_st), .memory_hold_state_i(mh_st),
    .lowpower_off_command_i(lpo), .ext_regulator_enable_bit_i(ext_en),
    .ext_regulator_lowpower_select_i(ext_lp),
    .ext_regulator_sleep_response_i(ext_rs),
    .int_regulator_enable_bit_i(int_en),
    .int_regulator_sleep_response_i(int_rs),
    .general_purpose_output_enable_i(gpo_en),
    .general_purpose_output_sleep_response_i(gpo_rs),
    .switcher_mode_field_i(swf), .switcher_user_off_keep_i(uo_keep),
    .switcher_memory_hold_keep_i(mh_keep), .switcher_light_load_i(light),
    .sleep_active_o(sleep), .sleep_entry_pending_o(pend),
    .ext_regulator_on_o(ext_on), .ext_regulator_lowpower_o(ext_lpo),
    .int_regulator_on_o(int_on), .general_purpose_output_o(gpo_o),
    .switcher_op_o(sw_op), .switcher_mode_illegal_o(sw_ill),
    .rb_ext_regulator_enable_bit_o(rb_ext_en),
    .rb_ext_regulator_lowpower_select_o(rb_ext_lp),
    .rb_int_regulator_enable_bit_o(rb_int_en),
    .rb_switcher_mode_field_o(rb_swf));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic ok, input string what);
    check_count++;
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  // returns some cycles after a slow edge so requests never race one
  task automatic wait_slow();
    int e;
    e = slow_edges;
    for (int i = 0; i < 8000 && slow_edges == e; i++)
      step(1);
    if (slow_edges == e)
    begin
      err_total++;
      $display("Error at %0t: slow clock stuck", $time);
      test_done();
    end
    step(10);
  endtask
  task automatic wait_sleep();
    for (int i = 0; i < 25000 && sleep !== 1'b1; i++)
      step(1);
    if (sleep !== 1'b1)
    begin
      err_total++;
      $display("Error at %0t: standby never entered", $time);
      test_done();
    end
  endtask
  function automatic smc_op_type op_of(input byte c, input logic lt);
    case (c)
      "W": op_of = SMC_OP_PWM;
      "S": op_of = SMC_OP_PULSE_SKIPPING_PWM;
      "F": op_of = SMC_OP_PFM;
      "A": op_of = lt ? SMC_OP_PFM : SMC_OP_PULSE_SKIPPING_PWM;
      default: op_of = SMC_OP_OFF;
    endcase
  endfunction
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_polarity();
    dly = 2'h0;
    for (int k = 0; k < 16; k++)
    begin
      {want_p, want_s, pol_p, pol_s} = k[3:0];
      step(2);
      chk(sleep === (want_p & want_s), "pin decode");
    end
    {want_p, want_s, pol_p, pol_s} = 4'h0;
  endtask
  task automatic t_gating();
    {want_p, want_s, on_st} = 3'b110;
    step(2);
    chk(sleep === 1'b0, "pins used outside on");
    {on_st, lpo} = 2'b11;
    step(2);
    chk(sleep === 1'b0, "off command lost");
    lpo = 1'b0;
    step(2);
    chk(sleep === 1'b1, "no standby");
    {want_p, want_s} = 2'b00;
  endtask
  task automatic t_delay(input logic [1:0] n);
    int e;
    dly = n;
    wait_slow();
    e = slow_edges;
    {want_p, want_s} = 2'b11;
    step(2);
    chk(pend === 1'b1 && sleep === 1'b0, "wait not started");
    wait_sleep();
    chk(slow_edges - e == n, "wrong entry delay");
    {want_p, want_s} = 2'b00;
    step(1);
    chk(sleep === 1'b0, "late exit");
  endtask
  task automatic t_cancel();
    int e;
    dly = 2'h2;
    wait_slow();
    {want_p, want_s} = 2'b11;
    wait_slow();
    chk(pend === 1'b1, "wait lost");
    {want_p, want_s} = 2'b10;
    step(1);
    chk(pend === 1'b0 && sleep === 1'b0, "wait kept");
    e = slow_edges;
    {want_p, want_s} = 2'b11;
    wait_sleep();
    chk(slow_edges - e == 2, "count kept");
    {want_p, want_s} = 2'b00;
  endtask
  task automatic t_supplies();
    dly = 2'h0;
    {ext_en, ext_lp, ext_rs, gpo_en, gpo_rs} = 20'he_a_c_7_5;
    {int_en, int_rs} = {6'h3e, 6'h2a};
    swf = {4{4'h1}};
    step(2);
    chk(ext_on === 4'he && (ext_lpo & ext_on) === 4'ha, "ext");
    chk(int_on === 6'h3e && gpo_o === 4'h7, "int");
    {want_p, want_s} = 2'b11;
    step(2);
    chk(ext_on === 4'ha && (ext_lpo & ext_on) === 4'ha, "ext sb");
    chk(int_on === 6'h14 && gpo_o === 4'h2, "int sb");
    chk(rb_ext_en === 4'he && rb_ext_lp === 4'ha, "rb ext");
    chk(rb_int_en === 6'h3e && rb_swf === {4{4'h1}}, "rb");
    {want_p, want_s} = 2'b00;
  endtask
  task automatic t_switchers();
    string nm, sb;
    nm = "OWSFAWWOAWSSAWSF";
    sb = "OOOOOWAOASSAFFFF";
    light = 4'h5;
    for (int s = 0; s < 2; s++)
      for (int c = 0; c < 16; c++)
      begin
        {want_p, want_s} = {2{s[0]}};
        swf = {4{c[3:0]}};
        step(2);
        chk(sw_ill === {4{c == 7}}, "illegal flag");
        for (int j = 0; j < 4; j++)
          chk(sw_op[j] === op_of(s ? sb[c] : nm[c], light[j]),
            "switcher mode");
      end
    {want_p, want_s} = 2'b00;
  endtask
  task automatic t_lowpower_off();
    swf = {4{4'h1}};
    {on_st, uo_st, lpo, uo_keep, mh_keep} = 11'b011_0011_1001;
    step(2);
    chk(sw_op === {SMC_OP_OFF, SMC_OP_OFF, SMC_OP_PFM, SMC_OP_PFM},
      "user off");
    {uo_st, mh_st} = 2'b01;
    step(2);
    chk(sw_op === {SMC_OP_PFM, SMC_OP_OFF, SMC_OP_OFF, SMC_OP_PFM},
      "memory hold");
    {on_st, mh_st, lpo} = 3'b100;
  endtask
  initial
  begin
    {clk_sys_i, rst_n_i, want_p, want_s, pol_p, pol_s} = '0;
    {uo_st, mh_st, lpo, on_st, dly} = 6'b000101;
    {ext_en, ext_lp, ext_rs, gpo_en, gpo_rs} = '0;
    {int_en, int_rs, uo_keep, mh_keep, light, swf} = '0;
    step(5);
    chk(sleep === 1'b0 && pend === 1'b0, "reset value");
    rst_n_i = 1'b1;
    t_polarity();
    t_gating();
    t_delay(2'h1);
    t_delay(2'h3);
    t_cancel();
    t_supplies();
    t_switchers();
    t_lowpower_off();
    test_done();
  end
endmodule
